// >>> rtl/rlsd_switch.sv
// control and diagnostics for one open-drain low-side switch on a resistive load
//
// Summary of operation
// - the switch turns on only from the on-command bit that software writes; it turns off from that bit or from a shutdown.
// - open load sets a status-only flag after the below-threshold comparator holds for T2.
// - open-load filtering runs only while the driver is commanded off.
// - the drain-level status bit follows the drain comparator filtered for T1 on both edges.
// - overcurrent held for T1 switches the driver off and sets the overcurrent fault flag.
// - overtemperature held for T1 switches the driver off and sets the overtemp fault flag.
// - an overcurrent or overtemperature shutdown also clears the stored on-command.
// - an overtemperature fault clears only once the filtered temperature condition is gone.
// - any reset forces the driver off and returns all control and status bits to initial state.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rlsd_consts.svh"
module rlsd_switch
   import rlsd_pkg::*;
#(
   parameter int T1_CYC = `RLSD_T1_CYC,
   parameter int T2_CYC = `RLSD_T2_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // comparators from the output stage
   input wire rlsd_cmp_t cmp,
   // gate drive and interrupt
   output logic resistive_load_output,
   output logic irq
);
   // ==========================================================
   // bus decode
   wire logic acc = psel && penable;
   wire logic wr = acc && pwrite;
   wire logic hit_ctrl = (paddr == `RLSD_CTRL_OFS);
   wire logic hit_stat = (paddr == `RLSD_STAT_OFS);
   wire logic hit_ist = (paddr == `RLSD_IRQ_STAT_OFS);
   wire logic hit_ien = (paddr == `RLSD_IRQ_EN_OFS);
   wire logic hit_icl = (paddr == `RLSD_IRQ_CLR_OFS);
   wire logic mapped = hit_ctrl | hit_stat | hit_ist | hit_ien | hit_icl;
   wire logic fault_clear_cmd = wr && hit_ctrl && pwdata[`RLSD_CTRL_CLR_BIT];
   wire logic on_write = wr && hit_ctrl;

   // ==========================================================
   // state
   logic switch_on_cmd_r;
   logic switch_on_cmd_nxt;
   logic overcurrent_fault_flag_r;
   logic overcurrent_fault_flag_nxt;
   logic overtemp_fault_flag_r;
   logic overtemp_fault_flag_nxt;
   logic open_load_flag_r;
   logic open_load_flag_nxt;
   logic drv_r;
   logic drv_nxt;
   rlsd_state_t state_r;
   rlsd_state_t state_nxt;
   logic [`RLSD_IRQ_W-1:0] ist_r;
   logic [`RLSD_IRQ_W-1:0] ist_nxt;
   logic [`RLSD_IRQ_W-1:0] ien_r;
   logic [`RLSD_IRQ_W-1:0] ien_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pslverr_r;
   logic irq_r;

   // ==========================================================
   // comparator filters
   logic open_filt;
   logic drain_level_status;
   logic oc_filt;
   logic ot_filt;

   // open-load filter frozen while the driver is commanded on
   rlsd_filter #(.CYCLES(T2_CYC), .INIT(1'b0)) u_open (
      .pclk(pclk), .presetn(presetn), .hold(switch_on_cmd_r),
      .din(cmp.below_thr), .dout(open_filt));
   rlsd_filter #(.CYCLES(T1_CYC), .INIT(1'b0)) u_drain (
      .pclk(pclk), .presetn(presetn), .hold(1'b0),
      .din(cmp.drain_high), .dout(drain_level_status));
   rlsd_filter #(.CYCLES(T1_CYC), .INIT(1'b0)) u_oc (
      .pclk(pclk), .presetn(presetn), .hold(1'b0),
      .din(cmp.overcurrent), .dout(oc_filt));
   rlsd_filter #(.CYCLES(T1_CYC), .INIT(1'b0)) u_ot (
      .pclk(pclk), .presetn(presetn), .hold(1'b0),
      .din(cmp.overtemp), .dout(ot_filt));

   // ==========================================================
   // fault and command logic
   wire logic oc_trip = oc_filt && !overcurrent_fault_flag_r;
   wire logic ot_trip = ot_filt && !overtemp_fault_flag_r;
   wire logic shutdown = oc_filt || ot_filt;
   wire logic ol_set = open_filt && !switch_on_cmd_r;
   wire logic faulted = overcurrent_fault_flag_nxt || overtemp_fault_flag_nxt;

   // a new trip wins over a clear arriving in the same cycle
   assign overcurrent_fault_flag_nxt = oc_filt
      || (overcurrent_fault_flag_r && !fault_clear_cmd);
   // overtemp stays latched while the filtered condition persists
   assign overtemp_fault_flag_nxt = ot_filt
      || (overtemp_fault_flag_r && !fault_clear_cmd);
   assign open_load_flag_nxt = ol_set
      || (open_load_flag_r && !fault_clear_cmd);
   // shutdown clears the stored command; on-command ignored while a fault is latched
   assign switch_on_cmd_nxt = shutdown ? 1'b0 :
      (on_write ? (pwdata[`RLSD_CTRL_ON_BIT] && !faulted) : switch_on_cmd_r);
   assign drv_nxt = switch_on_cmd_nxt;
   assign state_nxt = faulted ? RLSD_FAULT : (switch_on_cmd_nxt ? RLSD_ON : RLSD_OFF);

   // ==========================================================
   // interrupts: open load, overcurrent, overtemp events
   wire logic [`RLSD_IRQ_W-1:0] ev = {ot_trip, oc_trip, ol_set && !open_load_flag_r};
   wire logic [`RLSD_IRQ_W-1:0] icl = (wr && hit_icl) ? pwdata[`RLSD_IRQ_W-1:0] : '0;
   assign ist_nxt = ev | (ist_r & ~icl);
   assign ien_nxt = (wr && hit_ien) ? pwdata[`RLSD_IRQ_W-1:0] : ien_r;

   // ==========================================================
   // read mux
   wire logic [31:0] stat_word = {27'h0000000, drv_r, drain_level_status,
      overtemp_fault_flag_r, overcurrent_fault_flag_r, open_load_flag_r};
   wire logic [31:0] ctrl_word = {31'h00000000, switch_on_cmd_r};
   assign prdata_nxt = !(acc && !pwrite) ? 32'h00000000 :
      hit_ctrl ? ctrl_word :
      hit_stat ? stat_word :
      hit_ist ? {29'h00000000, ist_r} :
      hit_ien ? {29'h00000000, ien_r} : 32'h00000000;

   // zero-wait apb: pready held high, read data registered during setup
   logic [31:0] rd_hold;
   assign rd_hold = (psel && !penable && !pwrite) ?
      (hit_ctrl ? ctrl_word : hit_stat ? stat_word :
       hit_ist ? {29'h00000000, ist_r} : hit_ien ? {29'h00000000, ien_r} : 32'h00000000)
      : prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_on_cmd_r <= 1'b0;
         overcurrent_fault_flag_r <= 1'b0;
         overtemp_fault_flag_r <= 1'b0;
         open_load_flag_r <= 1'b0;
         drv_r <= 1'b0;
         state_r <= RLSD_OFF;
         ist_r <= '0;
         ien_r <= '0;
         irq_r <= 1'b0;
      end else begin
         switch_on_cmd_r <= switch_on_cmd_nxt;
         overcurrent_fault_flag_r <= overcurrent_fault_flag_nxt;
         overtemp_fault_flag_r <= overtemp_fault_flag_nxt;
         open_load_flag_r <= open_load_flag_nxt;
         drv_r <= drv_nxt;
         state_r <= state_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         irq_r <= |(ist_nxt & ien_nxt);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= rd_hold;
         pslverr_r <= psel && !penable && !mapped;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = pslverr_r;
   assign resistive_load_output = drv_r;
   assign irq = irq_r;

   // ==========================================================
   // checks
   oc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      oc_filt |=> !resistive_load_output) else $error("driver on during overcurrent");
   ot_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      ot_filt |=> !resistive_load_output) else $error("driver on during overtemp");
   cmd_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (oc_filt || ot_filt) |=> !switch_on_cmd_r) else $error("on command kept after trip");
   drv_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
      resistive_load_output == switch_on_cmd_r) else $error("driver differs from command");
   ol_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (switch_on_cmd_r && !open_load_flag_r) |=> !open_load_flag_r)
      else $error("open load set while on");
   ol_status_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ol_set && !shutdown && on_write && pwdata[0] && !faulted) |=> resistive_load_output)
      else $error("open load blocked driver");
   ot_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ot_filt && overtemp_fault_flag_r) |=> overtemp_fault_flag_r)
      else $error("overtemp cleared while hot");
   flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (overcurrent_fault_flag_r && !fault_clear_cmd) |=> overcurrent_fault_flag_r)
      else $error("overcurrent flag lost");
   drain_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(drain_level_status) |-> $past(cmp.drain_high))
      else $error("drain status rose without input");
endmodule : rlsd_switch

// >>> rtl/rlsd_consts.svh
// register offsets, field positions and filter timing for the load switch block
`ifndef RLSD_CONSTS_SVH
`define RLSD_CONSTS_SVH

// ==========================================================
// register byte offsets
`define RLSD_CTRL_OFS 12'h000
`define RLSD_STAT_OFS 12'h004
`define RLSD_IRQ_STAT_OFS 12'h008
`define RLSD_IRQ_EN_OFS 12'h00C
`define RLSD_IRQ_CLR_OFS 12'h010

// ==========================================================
// control fields
`define RLSD_CTRL_ON_BIT 0
`define RLSD_CTRL_CLR_BIT 1

// ==========================================================
// status fields, same layout in the interrupt registers
`define RLSD_ST_OPEN_BIT 0
`define RLSD_ST_OC_BIT 1
`define RLSD_ST_OT_BIT 2
`define RLSD_ST_DRAIN_BIT 3
`define RLSD_ST_DRV_BIT 4
`define RLSD_IRQ_W 3

// ==========================================================
// filter times in ns and derived cycles at 100 ns per clock
`define RLSD_CLK_PERIOD_NS 100
`define RLSD_T1_NS 10000
`define RLSD_T2_NS 100000
`define RLSD_T1_CYC ((`RLSD_T1_NS + `RLSD_CLK_PERIOD_NS - 1) / `RLSD_CLK_PERIOD_NS)
`define RLSD_T2_CYC ((`RLSD_T2_NS + `RLSD_CLK_PERIOD_NS - 1) / `RLSD_CLK_PERIOD_NS)

`endif

// >>> rtl/rlsd_pkg.sv
// types shared by the load switch block
package rlsd_pkg;
   // ==========================================================
   // raw comparator levels
   typedef struct packed {
      logic below_thr;
      logic drain_high;
      logic overcurrent;
      logic overtemp;
   } rlsd_cmp_t;

   // ==========================================================
   // driver state
   typedef enum logic [1:0] {
      RLSD_OFF = 2'b00,
      RLSD_ON = 2'b01,
      RLSD_FAULT = 2'b10
   } rlsd_state_t;
endpackage : rlsd_pkg

// >>> rtl/rlsd_filter.sv
// digital filter: output changes after the input holds a new level for a set time
`timescale 1ns/1ps
module rlsd_filter #(
   parameter int CYCLES = 100,
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // filter control
   input wire logic hold,
   input wire logic din,
   output logic dout
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic dout_r;
   logic dout_nxt;
   wire logic differs = (din != dout_r);
   wire logic expire = (cnt_r == CW'(CYCLES - 1));

   // counting restarts whenever input agrees with output, so glitches never accumulate
   assign cnt_nxt = (hold || !differs || expire) ? '0 : cnt_r + CW'(1);
   assign dout_nxt = (!hold && differs && expire) ? din : dout_r;
   assign dout = dout_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         dout_r <= INIT;
      end else begin
         cnt_r <= cnt_nxt;
         dout_r <= dout_nxt;
      end
   end
endmodule : rlsd_filter

// >>> sim/rlsd_load_model.sv
// behavioural resistive load and comparators of the output stage
`timescale 1ns/1ps
module rlsd_load_model
   import rlsd_pkg::*;
(
   // gate drive
   input wire logic resistive_load_output,
   // faults set by the bench
   input wire logic open_load,
   input wire logic shorted,
   input wire logic hot,
   // comparator levels
   output rlsd_cmp_t cmp
);
   // a live load pulls the open drain high only while the switch is off
   assign cmp.drain_high = !resistive_load_output && !open_load;
   assign cmp.below_thr = resistive_load_output || open_load;
   assign cmp.overcurrent = resistive_load_output && shorted;
   assign cmp.overtemp = hot;
endmodule : rlsd_load_model

// >>> sim/tb.sv
// self-checking bench for the load switch control block
`timescale 1ns/1ps
`include "rlsd_consts.svh"
module tb;
   import rlsd_pkg::*;
   // short filters keep the run brief
   localparam int T1 = 4;
   localparam int T2 = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic open_load = 1'b0;
   logic shorted = 1'b0;
   logic hot = 1'b0;
   rlsd_cmp_t cmp;
   logic resistive_load_output;
   logic irq;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   always #50 pclk = ~pclk;
   rlsd_switch #(.T1_CYC(T1), .T2_CYC(T2)) u_rlsd_switch (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp(cmp),
      .resistive_load_output(resistive_load_output), .irq(irq));
   rlsd_load_model u_rlsd_load_model (.resistive_load_output(resistive_load_output),
      .open_load(open_load), .shorted(shorted), .hot(hot), .cmp(cmp));
   // ==========================================================
   // helpers
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         results;
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // ends on a falling edge so outputs are settled when looked at
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : tick
   // one full transfer; waits an edge first so strobes never change twice in a step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request stands until pready is seen high at a rising edge; answer taken there
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic faults(input logic o, input logic s, input logic h);
      @(posedge pclk);
      open_load <= o;
      shorted <= s;
      hot <= h;
   endtask : faults
   // ==========================================================
   // scenarios
   task automatic t_onoff;
      tick(T1 + 2);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("drain off", rd[`RLSD_ST_DRAIN_BIT], 1'b1);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000001);
      tick(2);
      chk("drive on", resistive_load_output, 1'b1);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("drain filtered", rd[`RLSD_ST_DRAIN_BIT], 1'b1);
      tick(T1 + 2);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("drain low", rd[`RLSD_ST_DRAIN_BIT], 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000000);
      tick(2);
      chk("drive off", resistive_load_output, 1'b0);
   endtask : t_onoff
   task automatic t_open;
      faults(1'b1, 1'b0, 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000001);
      tick(2 * T2);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("open while on", rd[`RLSD_ST_OPEN_BIT], 1'b0);
      chk("open no trip", resistive_load_output, 1'b1);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000000);
      tick(T2 + 2);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("open flag", rd[`RLSD_ST_OPEN_BIT], 1'b1);
      faults(1'b0, 1'b0, 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000002);
   endtask : t_open
   task automatic t_oc;
      apb(1'b1, `RLSD_IRQ_EN_OFS, 32'h00000002);
      faults(1'b0, 1'b1, 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000001);
      tick(T1 + 4);
      chk("oc drive", resistive_load_output, 1'b0);
      chk("oc irq", irq, 1'b1);
      apb(1'b0, `RLSD_CTRL_OFS, 32'h0);
      chk("oc cmd", rd, 32'h00000000);
      faults(1'b0, 1'b0, 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000001);
      tick(T1 + 2);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("oc latched", rd[`RLSD_ST_OC_BIT], 1'b1);
      chk("oc stays off", resistive_load_output, 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000002);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("oc cleared", rd[`RLSD_ST_OC_BIT], 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000001);
      tick(2);
      chk("oc recover", resistive_load_output, 1'b1);
      apb(1'b0, `RLSD_IRQ_STAT_OFS, 32'h0);
      chk("irq status", rd, 32'h00000003);
      apb(1'b0, `RLSD_IRQ_EN_OFS, 32'h0);
      chk("irq enable", rd, 32'h00000002);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("drive status", rd[`RLSD_ST_DRV_BIT], 1'b1);
      chk("mapped ok", err, 1'b0);
      apb(1'b1, `RLSD_IRQ_CLR_OFS, 32'h00000002);
      tick(2);
      chk("irq clear", irq, 1'b0);
   endtask : t_oc
   task automatic t_ot;
      faults(1'b0, 1'b0, 1'b1);
      tick(T1 + 4);
      chk("ot drive", resistive_load_output, 1'b0);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000002);
      apb(1'b0, `RLSD_STAT_OFS, 32'h0);
      chk("ot hot", rd[`RLSD_ST_OT_BIT], 1'b1);
      faults(1'b0, 1'b0, 1'b0);
      tick(T1 + 2);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000002);
      apb(1'b1, `RLSD_CTRL_OFS, 32'h00000001);
      tick(2);
      chk("ot recover", resistive_load_output, 1'b1);
   endtask : t_ot
   task automatic t_reset;
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h00000000);
      @(posedge pclk);
      presetn <= 1'b0;
      tick(2);
      chk("reset drive", resistive_load_output, 1'b0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `RLSD_CTRL_OFS, 32'h0);
      chk("reset cmd", rd, 32'h00000000);
   endtask : t_reset
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_onoff;
      t_open;
      t_oc;
      t_ot;
      t_reset;
      results;
   end
endmodule : tb
